// [tb/pwm_edge_timing_checker.sv]
/*
 Checker for the PWM edge-timing block: bus handshake, register read
 layout and output relations.
 Assumes it is bound to the block's top module, one clock domain.
*/
`timescale 1ns/1ps
module pwm_edge_timing_checker (
   input wire logic aclk,               // Clock
   input wire logic aresetn,            // Sync reset, active low
   input wire logic s_axi_awvalid,      // Write address valid
   input wire logic s_axi_awready,      // Write address ready
   input wire logic s_axi_wvalid,       // Write data valid
   input wire logic s_axi_wready,       // Write data ready
   input wire logic [1:0] s_axi_bresp,  // Write response
   input wire logic s_axi_bvalid,       // Write response valid
   input wire logic s_axi_bready,       // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid,      // Read address valid
   input wire logic s_axi_arready,      // Read address ready
   input wire logic [31:0] s_axi_rdata, // Read data
   input wire logic [1:0] s_axi_rresp,  // Read response
   input wire logic s_axi_rvalid,       // Read data valid
   input wire logic s_axi_rready,       // Read data ready
   input wire logic shutdown_in,        // Shutdown request
   input wire logic feedback_in,        // Feedback input
   input wire logic pwm_out,            // Primary output
   input wire logic pwm_comp_out,       // Complementary output
   input wire logic shutdown_active,    // Latched shutdown
   input wire logic feedback_event      // Feedback pulse
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ---------------------------------------------------------------
   // Address of the read in flight
   // ---------------------------------------------------------------
   logic [7:0] rd_addr_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_addr_r <= 8'h00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rd_addr_r <= s_axi_araddr;
      end
   end
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   property p_wr_resp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response not in two cycles");
   property p_wr_refuse;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_wr_refuse: assert property (p_wr_refuse) else $error("write taken while response open");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_rd_resp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read data not one cycle after address");
   property p_frac_upper;
      s_axi_rvalid && rd_addr_r == pwm_timing_pkg::OFS_FRAC_ADJ |-> s_axi_rdata[31:4] == 28'h0;
   endproperty
   a_frac_upper: assert property (p_frac_upper) else $error("fraction upper bits not zero");
   property p_byte_regs;
      s_axi_rvalid && rd_addr_r <= pwm_timing_pkg::OFS_RISE_BLANK && rd_addr_r[1:0] == 2'h0
         |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == pwm_timing_pkg::RESP_OKAY;
   endproperty
   a_byte_regs: assert property (p_byte_regs) else $error("byte register read malformed");
   property p_unmapped;
      s_axi_rvalid && {rd_addr_r[7:2], 2'b00} > pwm_timing_pkg::OFS_STATUS
         |-> s_axi_rresp == pwm_timing_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   property p_comp_excl;
      !(pwm_out && pwm_comp_out);
   endproperty
   a_comp_excl: assert property (p_comp_excl) else $error("both outputs high");
   property p_fb_cause;
      feedback_event |-> $past(feedback_in);
   endproperty
   a_fb_cause: assert property (p_fb_cause) else $error("feedback pulse without input");
   property p_shut_cause;
      $rose(shutdown_active) |-> $past(shutdown_in);
   endproperty
   a_shut_cause: assert property (p_shut_cause) else $error("shutdown without request");
endmodule

bind pwm_edge_timing pwm_edge_timing_checker i_pwm_edge_timing_checker (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .shutdown_in, .feedback_in, .pwm_out, .pwm_comp_out, .shutdown_active, .feedback_event
);

// [tb/testbench.sv]
/*
 Testbench for the PWM edge-timing block: register access, period and
 fractional length, dead band widths and blanking.
 Assumes a 100 MHz clock and the checker bound beside the block.
*/
`timescale 1ns/1ps
module testbench;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, shutdown_in, feedback_in, pwm_out, pwm_comp_out;
   logic shutdown_active, feedback_event, period_event;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] duty_count;
   logic [7:0] ofs [6];
   logic [7:0] pat;
   int n_fail = 0;
   int compares = 0;
   int n_fb = 0;
   int c;

   pwm_edge_timing i_pwm_edge_timing (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .duty_count, .shutdown_in,
      .feedback_in, .pwm_out, .pwm_comp_out, .shutdown_active, .feedback_event, .period_event
   );

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(negedge aclk) begin
      if (feedback_event === 1'b1) n_fb++;
   end
   // ---------------------------------------------------------------
   // Compare, bus and measurement tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input bit bad);
      bit ta, tw, tb;
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = (s_axi_awvalid && s_axi_awready) === 1'b1;
         tw = (s_axi_wvalid && s_axi_wready) === 1'b1;
         tb = s_axi_bvalid === 1'b1;
         if (tb) chk("bresp", {30'h0, s_axi_bresp}, {30'h0, bad ? 2'h2 : 2'h0});
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         n++;
      end while (!tb && n < 50);
      s_axi_bready <= 1'b0;
      if (!tb) chk("write_wait", 32'h1, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input bit bad);
      bit ta, tr;
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = (s_axi_arvalid && s_axi_arready) === 1'b1;
         tr = s_axi_rvalid === 1'b1;
         if (tr) chk("rdata", s_axi_rdata, exp);
         if (tr) chk("rresp", {30'h0, s_axi_rresp}, {30'h0, bad ? 2'h2 : 2'h0});
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         n++;
      end while (!tr && n < 50);
      s_axi_rready <= 1'b0;
      if (!tr) chk("read_wait", 32'h1, 32'h0);
   endtask
   task automatic span(input int k, output int cnt);
      cnt = 0;
      do @(negedge aclk); while (period_event !== 1'b1);
      repeat (k) begin
         do begin
            @(negedge aclk);
            cnt++;
         end while (period_event !== 1'b1);
      end
   endtask
   task automatic hi_width(input bit comp, output int cnt);
      cnt = 0;
      do @(negedge aclk); while ((comp ? pwm_comp_out : pwm_out) !== 1'b0);
      do @(negedge aclk); while ((comp ? pwm_comp_out : pwm_out) !== 1'b1);
      do begin
         @(negedge aclk);
         cnt++;
      end while ((comp ? pwm_comp_out : pwm_out) === 1'b1);
   endtask
   task automatic pulse();
      @(posedge aclk);
      shutdown_in <= 1'b1;
      feedback_in <= 1'b1;
      @(posedge aclk);
      shutdown_in <= 1'b0;
      feedback_in <= 1'b0;
      repeat (3) @(negedge aclk);
   endtask
   task automatic stop_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #500000;
      n_fail++;
      stop_test();
   end
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      ofs = '{pwm_timing_pkg::OFS_PERIOD_LOW, pwm_timing_pkg::OFS_PERIOD_HIGH,
              pwm_timing_pkg::OFS_RISE_DB, pwm_timing_pkg::OFS_FALL_DB,
              pwm_timing_pkg::OFS_FRAC_ADJ, pwm_timing_pkg::OFS_RISE_BLANK};
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
      {s_axi_rready, shutdown_in, feedback_in} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 52'h0;
      duty_count = 16'h0064;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 6; i++) rd(ofs[i], 32'h0, 1'b0);
      rd(pwm_timing_pkg::OFS_STATUS, 32'h0, 1'b0);
      for (int i = 0; i < 6; i++) begin
         pat = 8'hA5 + 8'(i);
         wr(ofs[i], {24'hFFFFFF, pat}, 4'hF, 1'b0);
         rd(ofs[i], {24'h0, i == 4 ? {4'h0, pat[3:0]} : pat}, 1'b0);
      end
      wr(ofs[5], 32'h77, 4'hE, 1'b0);
      rd(ofs[5], 32'hAA, 1'b0);
      rd(8'h40, 32'h0, 1'b1);
      wr(8'h40, 32'h1, 4'hF, 1'b1);
      $display("test registers done");
      wr(ofs[0], 32'h02, 4'hF, 1'b0);
      wr(ofs[1], 32'h01, 4'hF, 1'b0);
      for (int i = 2; i < 6; i++) wr(ofs[i], 32'h0, 4'hF, 1'b0);
      wr(pwm_timing_pkg::OFS_CONTROL, 32'h1, 4'hF, 1'b0);
      rd(pwm_timing_pkg::OFS_CONTROL, 32'h1, 1'b0);
      span(16, c);
      chk("period_span", 32'(c), 32'h1030);
      wr(ofs[4], 32'hF7, 4'hF, 1'b0);
      span(1, c);
      span(16, c);
      chk("frac_span", 32'(c), 32'h1037);
      $display("test period done");
      wr(ofs[4], 32'h0, 4'hF, 1'b0);
      wr(ofs[2], 32'h0A, 4'hF, 1'b0);
      wr(ofs[3], 32'h14, 4'hF, 1'b0);
      span(2, c);
      hi_width(1'b0, c);
      chk("rise_band", 32'(c), 32'h5A);
      hi_width(1'b1, c);
      chk("fall_band", 32'(c), 32'h8B);
      $display("test dead band done");
      wr(ofs[2], 32'h0, 4'hF, 1'b0);
      wr(ofs[3], 32'h0, 4'hF, 1'b0);
      wr(ofs[5], 32'h1E, 4'hF, 1'b0);
      span(1, c);
      pulse();
      chk("blanked_shutdown", {31'h0, shutdown_active}, 32'h0);
      repeat (40) @(posedge aclk);
      pulse();
      chk("open_shutdown", {31'h0, shutdown_active}, 32'h1);
      chk("feedback_count", 32'(n_fb), 32'h1);
      span(0, c);
      repeat (3) @(negedge aclk);
      chk("shutdown_clear", {31'h0, shutdown_active}, 32'h0);
      $display("test blanking done");
      stop_test();
   end
endmodule

// [verilog/edge_delay.sv]
/*
 Edge-delay counter: holds a count of clock periods and reports when the
 interval started by a trigger is still running.
 Assumes trigger is a one-cycle pulse in the aclk domain.
*/
`timescale 1ns/1ps
module edge_delay (
   input wire logic aclk,          // Clock
   input wire logic aresetn,       // Sync reset, active low
   input wire logic trigger,       // Start interval
   input wire logic [7:0] length,  // Interval length in clocks
   output logic busy,              // Interval running
   output logic done               // Pulse at interval end
);
   logic [7:0] cnt_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= 8'h00;
      end else if (trigger) begin
         cnt_r <= (length == 8'h00) ? 8'h00 : length - 8'h01;
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end

   // Interval spans the trigger cycle and length-1 more, so exactly length clocks
   assign busy = (trigger && length != 8'h00) || (cnt_r != 8'h00);
   assign done = busy && !(trigger ? (length > 8'h01) : (cnt_r > 8'h01));
endmodule

// [verilog/pwm_edge_timing.sv]
/*
 PWM edge-timing slice: period counter with fractional adjust, duty
 compare, complementary outputs with rising and falling dead band, and
 rising-edge blanking of shutdown and feedback inputs. AXI4-Lite slave.
 Assumes a single 100 MHz clock that is the timebase, and sync inputs.
*/
// Contract
// [R1] The period high byte forms bits 15:8 of the 16-bit period count.
// [R2] The period low byte forms bits 7:0 of the same period count.
// [R3] The rising dead-band byte delays the rising edge by that many clocks.
// [R4] The falling dead-band byte delays the falling edge by that many clocks.
// [R5] The 4-bit fractional adjust is added to the time of every period event.
// [R6] One fractional step is one sixteenth of a clock, sixteen per clock.
// [R7] Bits 7:4 of the fractional adjust register read zero and ignore writes.
// [R8] The rising blanking byte is a count of clocks of blanking after a rising edge.
// [R9] Blanking masks shutdown and feedback, and dead band delays the active edge.
`timescale 1ns/1ps
module pwm_edge_timing (
   input wire logic aclk,               // Clock and timebase
   input wire logic aresetn,            // Sync reset, active low
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid,      // Write address valid
   output logic s_axi_awready,          // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb,  // Write strobes
   input wire logic s_axi_wvalid,       // Write data valid
   output logic s_axi_wready,           // Write data ready
   output logic [1:0] s_axi_bresp,      // Write response
   output logic s_axi_bvalid,           // Write response valid
   input wire logic s_axi_bready,       // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid,      // Read address valid
   output logic s_axi_arready,          // Read address ready
   output logic [31:0] s_axi_rdata,     // Read data
   output logic [1:0] s_axi_rresp,      // Read response
   output logic s_axi_rvalid,           // Read data valid
   input wire logic s_axi_rready,       // Read data ready
   input wire logic [15:0] duty_count,  // Duty compare value
   input wire logic shutdown_in,        // Shutdown request
   input wire logic feedback_in,        // Feedback event
   output logic pwm_out,                // Primary output
   output logic pwm_comp_out,           // Complementary output
   output logic shutdown_active,        // Latched shutdown
   output logic feedback_event,         // Unblanked feedback pulse
   output logic period_event            // Period event pulse
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] period_count_low_byte_r;
   logic [7:0] period_count_high_byte_r;
   logic [7:0] rising_dead_band_count_r;
   logic [7:0] falling_dead_band_count_r;
   logic [pwm_timing_pkg::FRAC_W-1:0] fractional_period_adjust_r;
   logic [7:0] rising_blanking_count_r;
   logic enable_r;
   logic [15:0] period_count;
   logic [15:0] tmr_r;
   logic [pwm_timing_pkg::FRAC_W-1:0] frac_acc_r;
   logic frac_carry;
   logic frac_stretch_r;
   logic raw_r;
   logic raw_d_r;
   logic rise_pulse;
   logic fall_pulse;
   logic rise_busy, fall_busy, blank_busy;
   logic aw_got_r, w_got_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_fire;

   function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
      merge_byte = s[0] ? d[7:0] : old;
   endfunction

   // [R1] [R2] Period assembly
   assign period_count = {period_count_high_byte_r, period_count_low_byte_r};

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
   assign s_axi_wready = !w_got_r && !s_axi_bvalid;
   assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pwm_timing_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            unique case ({awaddr_r[7:2], 2'b00})
               pwm_timing_pkg::OFS_PERIOD_LOW, pwm_timing_pkg::OFS_PERIOD_HIGH,
               pwm_timing_pkg::OFS_RISE_DB, pwm_timing_pkg::OFS_FALL_DB,
               pwm_timing_pkg::OFS_FRAC_ADJ, pwm_timing_pkg::OFS_RISE_BLANK,
               pwm_timing_pkg::OFS_CONTROL, pwm_timing_pkg::OFS_STATUS: begin
                  s_axi_bresp <= pwm_timing_pkg::RESP_OKAY;
               end
               default: begin
                  s_axi_bresp <= pwm_timing_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         period_count_low_byte_r <= pwm_timing_pkg::BYTE_RESET;
         period_count_high_byte_r <= pwm_timing_pkg::BYTE_RESET;
         rising_dead_band_count_r <= pwm_timing_pkg::BYTE_RESET;
         falling_dead_band_count_r <= pwm_timing_pkg::BYTE_RESET;
         fractional_period_adjust_r <= pwm_timing_pkg::FRAC_RESET;
         rising_blanking_count_r <= pwm_timing_pkg::BYTE_RESET;
         enable_r <= 1'b0;
      end else if (wr_fire) begin
         unique case ({awaddr_r[7:2], 2'b00})
            pwm_timing_pkg::OFS_PERIOD_LOW: begin
               period_count_low_byte_r <= merge_byte(period_count_low_byte_r, wdata_r, wstrb_r);
            end
            pwm_timing_pkg::OFS_PERIOD_HIGH: begin
               period_count_high_byte_r <= merge_byte(period_count_high_byte_r, wdata_r, wstrb_r);
            end
            pwm_timing_pkg::OFS_RISE_DB: begin
               rising_dead_band_count_r <= merge_byte(rising_dead_band_count_r, wdata_r, wstrb_r);
            end
            pwm_timing_pkg::OFS_FALL_DB: begin
               falling_dead_band_count_r <= merge_byte(falling_dead_band_count_r, wdata_r,
                                                       wstrb_r);
            end
            pwm_timing_pkg::OFS_FRAC_ADJ: begin
               // [R7] Upper bits dropped
               if (wstrb_r[0]) begin
                  fractional_period_adjust_r <= wdata_r[pwm_timing_pkg::FRAC_W-1:0];
               end
            end
            pwm_timing_pkg::OFS_RISE_BLANK: begin
               rising_blanking_count_r <= merge_byte(rising_blanking_count_r, wdata_r, wstrb_r);
            end
            pwm_timing_pkg::OFS_CONTROL: begin
               if (wstrb_r[0]) begin
                  enable_r <= wdata_r[pwm_timing_pkg::CTRL_EN_BIT];
               end
            end
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= pwm_timing_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= pwm_timing_pkg::RESP_OKAY;
         unique case ({s_axi_araddr[7:2], 2'b00})
            pwm_timing_pkg::OFS_PERIOD_LOW: s_axi_rdata <= {24'h000000, period_count_low_byte_r};
            pwm_timing_pkg::OFS_PERIOD_HIGH: s_axi_rdata <= {24'h000000, period_count_high_byte_r};
            pwm_timing_pkg::OFS_RISE_DB: s_axi_rdata <= {24'h000000, rising_dead_band_count_r};
            pwm_timing_pkg::OFS_FALL_DB: s_axi_rdata <= {24'h000000, falling_dead_band_count_r};
            // [R7] Reads zero above
            pwm_timing_pkg::OFS_FRAC_ADJ: s_axi_rdata <= {28'h0000000, fractional_period_adjust_r};
            pwm_timing_pkg::OFS_RISE_BLANK: s_axi_rdata <= {24'h000000, rising_blanking_count_r};
            pwm_timing_pkg::OFS_CONTROL: s_axi_rdata <= {31'h00000000, enable_r};
            pwm_timing_pkg::OFS_STATUS: s_axi_rdata <= {10'h000, blank_busy, shutdown_active,
                                                        raw_r, tmr_r, 3'h0};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= pwm_timing_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Timebase with fractional stretch
   // ---------------------------------------------------------------
   // [R5] [R6] Sixteenth-clock accumulator
   assign frac_carry = ({1'b0, frac_acc_r} + {1'b0, fractional_period_adjust_r})
                       >= 5'(pwm_timing_pkg::FRAC_STEPS);

   always_ff @(posedge aclk) begin
      if (!aresetn || !enable_r) begin
         tmr_r <= 16'h0000;
         frac_acc_r <= pwm_timing_pkg::FRAC_RESET;
         frac_stretch_r <= 1'b0;
         period_event <= 1'b0;
      end else begin
         period_event <= 1'b0;
         if (tmr_r >= period_count && !frac_stretch_r) begin
            // [R5] Carry adds one whole clock
            frac_acc_r <= frac_acc_r + fractional_period_adjust_r;
            if (frac_carry) begin
               frac_stretch_r <= 1'b1;
            end else begin
               tmr_r <= 16'h0000;
               period_event <= 1'b1;
            end
         end else if (frac_stretch_r) begin
            frac_stretch_r <= 1'b0;
            tmr_r <= 16'h0000;
            period_event <= 1'b1;
         end else begin
            tmr_r <= tmr_r + 16'h0001;
         end
      end
   end

   // ---------------------------------------------------------------
   // Raw PWM, dead band and blanking
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         raw_r <= 1'b0;
         raw_d_r <= 1'b0;
      end else begin
         raw_r <= enable_r && !shutdown_active && (tmr_r < duty_count);
         raw_d_r <= raw_r;
      end
   end

   assign rise_pulse = raw_r && !raw_d_r;
   assign fall_pulse = !raw_r && raw_d_r;

   // [R3] Rising dead band
   edge_delay u_rise_db (
      .aclk(aclk), .aresetn(aresetn), .trigger(rise_pulse), .length(rising_dead_band_count_r),
      .busy(rise_busy), .done()
   );

   // [R4] Falling dead band
   edge_delay u_fall_db (
      .aclk(aclk), .aresetn(aresetn), .trigger(fall_pulse), .length(falling_dead_band_count_r),
      .busy(fall_busy), .done()
   );

   // [R8] Rising blanking window
   edge_delay u_rise_blank (
      .aclk(aclk), .aresetn(aresetn), .trigger(rise_pulse), .length(rising_blanking_count_r),
      .busy(blank_busy), .done()
   );

   // [R9] Delay active edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_out <= 1'b0;
         pwm_comp_out <= 1'b0;
      end else begin
         pwm_out <= raw_r && !rise_busy;
         pwm_comp_out <= !raw_r && enable_r && !fall_busy;
      end
   end

   // [R9] Inputs masked while blanking
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable_r) begin
         shutdown_active <= 1'b0;
         feedback_event <= 1'b0;
      end else begin
         if (shutdown_in && !blank_busy) begin
            shutdown_active <= 1'b1;
         end else if (period_event && !shutdown_in) begin
            shutdown_active <= 1'b0;
         end
         feedback_event <= feedback_in && !blank_busy;
      end
   end
endmodule

// [verilog/pwm_timing_pkg.sv]
/*
 Package for the PWM edge-timing block: register offsets, field layout,
 reset values and widths.
 Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
*/
package pwm_timing_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_PERIOD_LOW = 8'h00;
   localparam logic [7:0] OFS_PERIOD_HIGH = 8'h04;
   localparam logic [7:0] OFS_RISE_DB = 8'h08;
   localparam logic [7:0] OFS_FALL_DB = 8'h0C;
   localparam logic [7:0] OFS_FRAC_ADJ = 8'h10;
   localparam logic [7:0] OFS_RISE_BLANK = 8'h14;
   localparam logic [7:0] OFS_CONTROL = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   // ---------------------------------------------------------------
   // Fields and reset values
   // ---------------------------------------------------------------
   localparam int FRAC_W = 4;
   localparam int FRAC_STEPS = 16;
   localparam int CTRL_EN_BIT = 0;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [FRAC_W-1:0] FRAC_RESET = 4'h0;
   localparam logic [15:0] DUTY_RESET = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
